// ### inc/twt_pkg.sv
// Constants shared by the two-wire target register bank and its bench.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`default_nettype none
package twt_pkg;
  localparam int unsigned ADR_W = 12;
  localparam int unsigned CNT_W = 13;
  localparam logic [11:0] OFS_IRQ_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFS_ERR = 12'h4d0;
  localparam logic [11:0] OFS_MATCH = 12'h4d4;
  localparam logic [11:0] OFS_ON = 12'h500;
  localparam logic [11:0] OFS_SCL_SEL = 12'h508;
  localparam logic [11:0] OFS_SDA_SEL = 12'h50c;
  localparam logic [11:0] OFS_RX_PTR = 12'h534;
  localparam logic [11:0] OFS_RX_LIM = 12'h538;
  localparam logic [11:0] OFS_RX_CNT = 12'h53c;
  localparam logic [11:0] OFS_RX_LIST = 12'h540;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_LIM = 12'h548;
  localparam logic [11:0] OFS_TX_CNT = 12'h54c;
  localparam logic [11:0] OFS_TX_LIST = 12'h550;
  localparam logic [11:0] OFS_EVT = 12'h600;
  // Event bit positions, shared by the event status and enable registers.
  localparam int unsigned EV_STOPPED = 0;
  localparam int unsigned EV_ERROR = 9;
  localparam int unsigned EV_RX_BEGUN = 19;
  localparam int unsigned EV_TX_BEGUN = 20;
  localparam int unsigned EV_WRITE = 25;
  localparam int unsigned EV_READ = 26;
  localparam logic [31:0] EV_MASK = 32'h0618_0201;
  // Error cause bit positions.
  localparam int unsigned ER_OVERFLOW = 0;
  localparam int unsigned ER_DATA_NACK = 1;
  localparam int unsigned ER_OVER_READ = 2;
  localparam int unsigned PIN_LSB = 0;
  localparam int unsigned PIN_W = 5;
  localparam int unsigned CONNECT_BIT = 31;
  localparam int unsigned ON_W = 4;
  // Value of the enable field that switches the target on; arbitrary choice.
  localparam logic [3:0] ON_VALUE = 4'h1;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_SEL = 32'hffff_ffff;
  localparam logic LIST_OFF = 1'b0;
  localparam logic LIST_ARRAY = 1'b1;
endpackage
`default_nettype wire

// ### logic/twt_chan_count.sv
// Byte counter of one transfer channel of the two-wire target.
// Assumes start and step come from logic on the same clock.
`default_nettype none
module twt_chan_count (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic step_i,
  input wire logic [12:0] limit_i,
  output logic [12:0] count_o,
  output logic room_o
);
  typedef struct packed {
    logic [12:0] cnt;
  } twt_chan_state_t;

  twt_chan_state_t st_ff;
  twt_chan_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (start_i) begin
      nxt_st.cnt = 13'h0000;
    end else if (step_i) begin
      nxt_st.cnt = 13'(st_ff.cnt + 13'h0001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_o = st_ff.cnt;
  // A limit of zero leaves no room at all.
  assign room_o = (st_ff.cnt < limit_i);
endmodule // twt_chan_count
`default_nettype wire

// ### logic/twt_regs.sv
// Register bank of the two-wire target: Wishbone slave, error and event
// flags, pin selection and the receive and transmit buffer channels.
// Assumes the protocol engine drives its strobes on clk_i, one cycle each.
//
// Our own choice: the Wishbone slave port.
`default_nettype none
module twt_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic write_cmd_i,
  input wire logic read_cmd_i,
  input wire logic stopped_i,
  input wire logic addr_hit_i,
  input wire logic addr_hit_idx_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic data_nack_i,
  input wire logic tx_req_i,
  output logic irq_o,
  output logic target_on_o,
  output logic [4:0] scl_pin_o,
  output logic scl_disconnect_o,
  output logic [4:0] sda_pin_o,
  output logic sda_disconnect_o,
  output logic dma_wr_o,
  output logic dma_rd_o,
  output logic [31:0] dma_addr_o,
  output logic [7:0] dma_wdata_o,
  output logic tx_past_end_o
);
  typedef struct packed {
    logic [31:0] irq_enable_word;
    logic [31:0] evt;
    logic [2:0] error_cause;
    logic [1:0] hit;
    logic [3:0] on;
    // Decoded enable, kept in a flop so the pin-facing level is registered.
    logic is_on;
    logic [31:0] scl_sel;
    logic [31:0] sda_sel;
    logic [31:0] rx_ptr;
    logic [12:0] rx_lim;
    logic rx_list;
    logic [31:0] tx_ptr;
    logic [12:0] tx_lim;
    logic tx_list;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic dma_wr;
    logic dma_rd;
    logic [31:0] dma_addr;
    logic [7:0] dma_wdata;
    logic past_end;
  } twt_state_t;

  twt_state_t st_ff;
  twt_state_t nxt_st;

  logic [12:0] rx_cnt;
  logic [12:0] tx_cnt;
  logic rx_room;
  logic tx_room;
  logic on;
  logic rx_start;
  logic tx_start;
  logic rx_store;
  logic tx_fetch;

  // Bus access taken once per request; ack blocks a second take.
  logic acc;
  logic wr;
  logic [31:0] lane;
  logic [31:0] wmask;

  assign acc = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr = acc & wb_we_i;
  assign lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wmask = wb_dat_i & lane;

  // Engine strobes count only while the target is switched on.
  assign on = (st_ff.on == twt_pkg::ON_VALUE);
  assign rx_start = on & write_cmd_i;
  assign tx_start = on & read_cmd_i;
  assign rx_store = on & rx_valid_i & rx_room & ~rx_start;
  assign tx_fetch = on & tx_req_i & tx_room & ~tx_start;

  twt_chan_count u_rx_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(rx_start),
    .step_i(rx_store),
    .limit_i(st_ff.rx_lim),
    .count_o(rx_cnt),
    .room_o(rx_room)
  );

  twt_chan_count u_tx_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tx_start),
    .step_i(tx_fetch),
    .limit_i(st_ff.tx_lim),
    .count_o(tx_cnt),
    .room_o(tx_room)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [31:0] ln);
    merge = (old & ~ln) | (val & ln);
  endfunction

  function automatic logic [31:0] pad13(input logic [12:0] v);
    pad13 = {19'h00000, v};
  endfunction

  always_comb begin
    logic [31:0] ev_set;
    logic [2:0] er_set;
    logic [31:0] tmp;
    ev_set = 32'h0000_0000;
    er_set = 3'h0;
    tmp = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_st.ack = acc;
    nxt_st.dma_wr = 1'b0;
    nxt_st.dma_rd = 1'b0;
    nxt_st.past_end = 1'b0;

    // Hardware events, gathered before software clears.
    er_set[twt_pkg::ER_OVERFLOW] = on & rx_valid_i & ~rx_room
                                   & ~rx_start;
    er_set[twt_pkg::ER_DATA_NACK] = on & data_nack_i;
    er_set[twt_pkg::ER_OVER_READ] = on & tx_req_i & ~tx_room
                                    & ~tx_start;
    ev_set[twt_pkg::EV_STOPPED] = on & stopped_i;
    ev_set[twt_pkg::EV_ERROR] = |er_set;
    ev_set[twt_pkg::EV_RX_BEGUN] = rx_start;
    ev_set[twt_pkg::EV_WRITE] = rx_start;
    ev_set[twt_pkg::EV_TX_BEGUN] = tx_start;
    ev_set[twt_pkg::EV_READ] = tx_start;

    if (rx_store) begin
      nxt_st.dma_wr = 1'b1;
      nxt_st.dma_addr = st_ff.rx_ptr + pad13(rx_cnt);
      nxt_st.dma_wdata = rx_data_i;
    end else if (tx_fetch) begin
      nxt_st.dma_rd = 1'b1;
      nxt_st.dma_addr = st_ff.tx_ptr + pad13(tx_cnt);
    end
    // The engine sends its filler byte when this pulse comes back.
    nxt_st.past_end = er_set[twt_pkg::ER_OVER_READ];

    if (on & addr_hit_i) begin
      nxt_st.hit = addr_hit_idx_i ? 2'h2 : 2'h1;
    end

    // Register writes; set by hardware wins over a clearing write.
    if (wr) begin
      case (wb_adr_i)
        twt_pkg::OFS_IRQ_SET: begin
          nxt_st.irq_enable_word = st_ff.irq_enable_word
                                   | (wmask & twt_pkg::EV_MASK);
        end
        twt_pkg::OFS_IRQ_CLR: begin
          nxt_st.irq_enable_word = st_ff.irq_enable_word
                                   & ~wmask;
        end
        twt_pkg::OFS_ERR: begin
          nxt_st.error_cause = st_ff.error_cause & ~wmask[2:0];
        end
        twt_pkg::OFS_EVT: begin
          nxt_st.evt = st_ff.evt & ~wmask;
        end
        twt_pkg::OFS_ON: begin
          tmp = merge({28'h0000000, st_ff.on}, wb_dat_i, lane);
          nxt_st.on = tmp[3:0];
        end
        twt_pkg::OFS_SCL_SEL: begin
          nxt_st.scl_sel = merge(st_ff.scl_sel, wb_dat_i, lane);
        end
        twt_pkg::OFS_SDA_SEL: begin
          nxt_st.sda_sel = merge(st_ff.sda_sel, wb_dat_i, lane);
        end
        twt_pkg::OFS_RX_PTR: begin
          nxt_st.rx_ptr = merge(st_ff.rx_ptr, wb_dat_i, lane);
        end
        twt_pkg::OFS_RX_LIM: begin
          tmp = merge(pad13(st_ff.rx_lim), wb_dat_i, lane);
          nxt_st.rx_lim = tmp[12:0];
        end
        twt_pkg::OFS_RX_LIST: begin
          if (wb_sel_i[0]) begin
            nxt_st.rx_list = wb_dat_i[0];
          end
        end
        twt_pkg::OFS_TX_PTR: begin
          nxt_st.tx_ptr = merge(st_ff.tx_ptr, wb_dat_i, lane);
        end
        twt_pkg::OFS_TX_LIM: begin
          tmp = merge(pad13(st_ff.tx_lim), wb_dat_i, lane);
          nxt_st.tx_lim = tmp[12:0];
        end
        twt_pkg::OFS_TX_LIST: begin
          if (wb_sel_i[0]) begin
            nxt_st.tx_list = wb_dat_i[0];
          end
        end
        default: begin
          // Read-only and unmapped words ignore writes.
          nxt_st.hit = nxt_st.hit;
        end
      endcase
    end
    nxt_st.error_cause = nxt_st.error_cause | er_set;
    nxt_st.evt = nxt_st.evt | (ev_set & twt_pkg::EV_MASK);

    // The pin-facing enable is the decoded field, so a value other than the
    // on value reads as off here just as it does for the engine strobes.
    nxt_st.is_on = (nxt_st.on == twt_pkg::ON_VALUE);

    // Read data is captured with the ack; unmapped words read zero.
    nxt_st.rdata = 32'h0000_0000;
    if (acc & ~wb_we_i) begin
      case (wb_adr_i)
        twt_pkg::OFS_IRQ_SET: begin
          nxt_st.rdata = st_ff.irq_enable_word;
        end
        twt_pkg::OFS_IRQ_CLR: begin
          nxt_st.rdata = st_ff.irq_enable_word;
        end
        twt_pkg::OFS_ERR: begin
          nxt_st.rdata = {29'h0000000, st_ff.error_cause};
        end
        twt_pkg::OFS_EVT: begin
          nxt_st.rdata = st_ff.evt;
        end
        twt_pkg::OFS_MATCH: begin
          nxt_st.rdata = {30'h00000000, st_ff.hit};
        end
        twt_pkg::OFS_ON: begin
          nxt_st.rdata = {28'h0000000, st_ff.on};
        end
        twt_pkg::OFS_SCL_SEL: begin
          nxt_st.rdata = st_ff.scl_sel;
        end
        twt_pkg::OFS_SDA_SEL: begin
          nxt_st.rdata = st_ff.sda_sel;
        end
        twt_pkg::OFS_RX_PTR: begin
          nxt_st.rdata = st_ff.rx_ptr;
        end
        twt_pkg::OFS_RX_LIM: begin
          nxt_st.rdata = pad13(st_ff.rx_lim);
        end
        twt_pkg::OFS_RX_CNT: begin
          nxt_st.rdata = pad13(rx_cnt);
        end
        twt_pkg::OFS_RX_LIST: begin
          nxt_st.rdata = {31'h00000000, st_ff.rx_list};
        end
        twt_pkg::OFS_TX_PTR: begin
          nxt_st.rdata = st_ff.tx_ptr;
        end
        twt_pkg::OFS_TX_LIM: begin
          nxt_st.rdata = pad13(st_ff.tx_lim);
        end
        twt_pkg::OFS_TX_CNT: begin
          nxt_st.rdata = pad13(tx_cnt);
        end
        twt_pkg::OFS_TX_LIST: begin
          nxt_st.rdata = {31'h00000000, st_ff.tx_list};
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Level interrupt is registered from the next flags, so it changes in the same cycle as they do.
    nxt_st.irq = |(nxt_st.evt & nxt_st.irq_enable_word);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.scl_sel <= twt_pkg::RST_PIN_SEL;
      st_ff.sda_sel <= twt_pkg::RST_PIN_SEL;
      st_ff.rx_ptr <= twt_pkg::RST_ZERO;
      st_ff.tx_ptr <= twt_pkg::RST_ZERO;
      st_ff.rx_list <= twt_pkg::LIST_OFF;
      st_ff.tx_list <= twt_pkg::LIST_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign irq_o = st_ff.irq;
  assign target_on_o = st_ff.is_on;
  assign scl_pin_o = st_ff.scl_sel[4:0];
  assign scl_disconnect_o = st_ff.scl_sel[31];
  assign sda_pin_o = st_ff.sda_sel[4:0];
  assign sda_disconnect_o = st_ff.sda_sel[31];
  assign dma_wr_o = st_ff.dma_wr;
  assign dma_rd_o = st_ff.dma_rd;
  assign dma_addr_o = st_ff.dma_addr;
  assign dma_wdata_o = st_ff.dma_wdata;
  assign tx_past_end_o = st_ff.past_end;
endmodule // twt_regs
`default_nettype wire

// ### bench/twt_regs_chk.sv
// Port checker for the two-wire target register bank.
// Assumes one clock with a synchronous active-high reset.
`default_nettype none
module twt_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic read_cmd_i,
  input wire logic rx_valid_i,
  input wire logic tx_req_i,
  input wire logic irq_o,
  input wire logic target_on_o,
  input wire logic [4:0] scl_pin_o,
  input wire logic dma_wr_o,
  input wire logic dma_rd_o,
  input wire logic [31:0] dma_addr_o,
  input wire logic tx_past_end_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic bus_wr;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i;
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rx_store_a:
    assert property (dma_wr_o |-> $past(rx_valid_i && target_on_o))
    else $error("store without a byte");
  tx_fetch_a:
    assert property (dma_rd_o |-> $past(tx_req_i && target_on_o))
    else $error("fetch without a request");
  tx_answer_a:
    assert property ((tx_req_i && target_on_o && !read_cmd_i)
      |=> dma_rd_o != tx_past_end_o)
    else $error("fetch request not answered");
  past_end_a:
    assert property (tx_past_end_o |-> !dma_rd_o && $past(tx_req_i))
    else $error("over-read not blocked");
  addr_step_a:
    assert property ((dma_wr_o && $past(dma_wr_o))
      |-> dma_addr_o == $past(dma_addr_o) + 32'h1)
    else $error("store address not stepped");
  irq_drop_a:
    assert property ($fell(irq_o) |-> $past(bus_wr))
    else $error("interrupt fell without a write");
  pin_hold_a:
    assert property ($changed(scl_pin_o) |-> $past(bus_wr))
    else $error("clock pin changed without a write");
  irq_up_c: cover property ($rose(irq_o));
  past_end_c: cover property (tx_past_end_o);
  store_run_c: cover property (dma_wr_o ##1 dma_wr_o);
endmodule // twt_regs_chk
bind twt_regs twt_regs_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .read_cmd_i, .rx_valid_i, .tx_req_i, .irq_o,
  .target_on_o, .scl_pin_o, .dma_wr_o, .dma_rd_o, .dma_addr_o,
  .tx_past_end_o);
`default_nettype wire

// ### bench/twt_engine_model.sv
// Engine model pulsing the bank's strobes as the controller side does.
// Assumes the bank's clock; the bench calls burst and flag.
`default_nettype none
module twt_engine_model (
  input wire logic clk_i,
  output logic write_cmd_o,
  output logic read_cmd_o,
  output logic hit_o,
  output logic hit_idx_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic nack_o,
  output logic tx_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'ha4f4;
  logic [7:0] sent_q[$];
  initial {write_cmd_o, read_cmd_o, hit_o, hit_idx_o, rx_valid_o,
    rx_data_o, nack_o, tx_req_o} = 15'h0;
  // Start pulse first, then a byte or fetch request every cycle.
  task automatic burst(input logic rd, input int n);
    logic [7:0] b;
    @(posedge clk_i);
    {read_cmd_o, write_cmd_o} <= {rd, !rd};
    repeat (n) begin
      @(posedge clk_i);
      b = 8'($random(seed));
      if (!rd) sent_q.push_back(b);
      {read_cmd_o, write_cmd_o, tx_req_o, rx_valid_o, rx_data_o} <=
        {2'b00, rd, !rd, b};
    end
    @(posedge clk_i);
    // Idle data is inverted so a stale byte is never mistaken for news.
    {tx_req_o, rx_valid_o, rx_data_o} <= {2'b00, ~rx_data_o};
  endtask
  task automatic flag(input logic hit, input logic idx);
    @(posedge clk_i);
    {hit_o, hit_idx_o, nack_o} <= {hit, idx, !hit};
    @(posedge clk_i);
    {hit_o, hit_idx_o, nack_o} <= {1'b0, !idx, 1'b0};
  endtask
endmodule // twt_engine_model
`default_nettype wire

// ### bench/two_wire_target_regs_tb.sv
// Self-checking bench for the two-wire target register bank.
// Assumes one 100 MHz clock for bank, engine model and bench.
`default_nettype none
module two_wire_target_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, stopped_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, dma_addr_o, q, wa_q[$], ra_q[$];
  logic write_cmd_i, read_cmd_i, addr_hit_i, addr_hit_idx_i, rx_valid_i;
  logic data_nack_i, tx_req_i, wb_ack_o, irq_o, target_on_o, dma_wr_o;
  logic scl_disconnect_o, sda_disconnect_o, dma_rd_o, tx_past_end_o;
  logic [4:0] scl_pin_o, sda_pin_o;
  logic [7:0] rx_data_i, dma_wdata_o, wd_q[$];
  int fail_count = 0, compares = 0, ends = 0, p;
  logic [11:0] ofs[8] = '{twt_pkg::OFS_ERR, twt_pkg::OFS_MATCH,
    twt_pkg::OFS_ON, twt_pkg::OFS_SCL_SEL, twt_pkg::OFS_SDA_SEL,
    twt_pkg::OFS_RX_PTR, twt_pkg::OFS_RX_LIM, twt_pkg::OFS_TX_LIST};
  always #5 clk_i = ~clk_i;
  twt_regs uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .write_cmd_i, .read_cmd_i,
    .stopped_i, .addr_hit_i, .addr_hit_idx_i, .rx_valid_i, .rx_data_i,
    .data_nack_i, .tx_req_i, .irq_o, .target_on_o, .scl_pin_o,
    .scl_disconnect_o, .sda_pin_o, .sda_disconnect_o, .dma_wr_o, .dma_rd_o,
    .dma_addr_o, .dma_wdata_o, .tx_past_end_o);
  twt_engine_model pm (.clk_i, .write_cmd_o(write_cmd_i),
    .read_cmd_o(read_cmd_i), .hit_o(addr_hit_i), .hit_idx_o(addr_hit_idx_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .nack_o(data_nack_i),
    .tx_req_o(tx_req_i));
  // Memory traffic is logged here and judged once each transfer ends.
  always @(posedge clk_i) begin
    if (dma_wr_o === 1'b1) wa_q.push_back(dma_addr_o);
    if (dma_wr_o === 1'b1) wd_q.push_back(dma_wdata_o);
    if (dma_rd_o === 1'b1) ra_q.push_back(dma_addr_o);
    if (tx_past_end_o === 1'b1) ends++;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) fail_count++;
    if (s !== e) $display("MISMATCH %0t saw %h want %h", $time, s, e);
  endtask
  task automatic stop_test();
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic b(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    // No cycle count is assumed; the ack ends this wait, or else the watchdog.
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_dat_i} <= {2'b00, ~d};
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    b(1'b1, a, d);
  endtask
  task automatic r(input logic [11:0] a, input logic [31:0] e);
    b(1'b0, a, 32'h0);
    check(q, e);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) r(ofs[i], {32{i inside {3, 4}}});
    r(twt_pkg::OFS_RX_LIST, 32'h0);
    r(12'h0fc, 32'h0);
    p = $random(pm.seed);
    wr(twt_pkg::OFS_IRQ_SET, p);
    r(twt_pkg::OFS_IRQ_CLR, p & twt_pkg::EV_MASK);
    wr(twt_pkg::OFS_IRQ_CLR, 32'hffff_ffff);
    r(twt_pkg::OFS_IRQ_SET, 32'h0);
    wr(twt_pkg::OFS_SCL_SEL, 32'h0000_0005);
    check({scl_disconnect_o, scl_pin_o}, 32'h05);
    wr(twt_pkg::OFS_SDA_SEL, 32'h8000_001a);
    check({sda_disconnect_o, sda_pin_o}, 32'h3a);
    wr(twt_pkg::OFS_TX_LIST, 32'h1);
    r(twt_pkg::OFS_TX_LIST, 32'h1);
    wr(twt_pkg::OFS_RX_LIST, 32'h1);
    r(twt_pkg::OFS_RX_LIST, 32'h1);
    p = $random(pm.seed);
    wr(twt_pkg::OFS_RX_PTR, p);
    r(twt_pkg::OFS_RX_PTR, p);
    wr(twt_pkg::OFS_RX_LIM, 32'h3);
    wr(twt_pkg::OFS_ON, 32'(twt_pkg::ON_VALUE));
    check(target_on_o, 32'h1);
    wr(twt_pkg::OFS_IRQ_SET, 32'h1 << twt_pkg::EV_WRITE);
    pm.burst(1'b0, 4);
    check(irq_o, 32'h1);
    repeat (2) @(posedge clk_i);
    check(wa_q.size(), 32'h3);
    foreach (wa_q[i]) check(wa_q[i], p + i);
    foreach (wd_q[i]) check(wd_q[i], pm.sent_q[i]);
    wr(twt_pkg::OFS_RX_CNT, 32'h7);
    r(twt_pkg::OFS_RX_CNT, 32'h3);
    r(twt_pkg::OFS_ERR, 32'h1);
    wr(twt_pkg::OFS_EVT, 32'h1 << twt_pkg::EV_WRITE);
    check(irq_o, 32'h0);
    wr(twt_pkg::OFS_IRQ_SET, 32'h1 << twt_pkg::EV_ERROR);
    check(irq_o, 32'h1);
    wr(twt_pkg::OFS_IRQ_CLR, 32'h1 << twt_pkg::EV_ERROR);
    check(irq_o, 32'h0);
    wr(twt_pkg::OFS_ERR, 32'h1);
    pm.flag(1'b0, 1'b0);
    r(twt_pkg::OFS_ERR, 32'h2);
    wr(twt_pkg::OFS_ERR, 32'h2);
    pm.flag(1'b1, 1'b1);
    r(twt_pkg::OFS_MATCH, 32'h2);
    pm.flag(1'b1, 1'b0);
    r(twt_pkg::OFS_MATCH, 32'h1);
    wr(twt_pkg::OFS_EVT, 32'hffff_ffff);
    @(posedge clk_i);
    stopped_i <= 1'b1;
    @(posedge clk_i);
    stopped_i <= 1'b0;
    r(twt_pkg::OFS_EVT, 32'h1 << twt_pkg::EV_STOPPED);
    p = $random(pm.seed);
    wr(twt_pkg::OFS_TX_PTR, p);
    r(twt_pkg::OFS_TX_PTR, p);
    wr(twt_pkg::OFS_TX_LIM, 32'h2);
    pm.burst(1'b1, 3);
    repeat (2) @(posedge clk_i);
    check(ra_q.size(), 32'h2);
    foreach (ra_q[i]) check(ra_q[i], p + i);
    check(ends, 32'h1);
    r(twt_pkg::OFS_ERR, 32'h4);
    r(twt_pkg::OFS_TX_CNT, 32'h2);
    p = (32'h1 << twt_pkg::EV_STOPPED) | (32'h1 << twt_pkg::EV_ERROR);
    p = p | (32'h1 << twt_pkg::EV_TX_BEGUN) | (32'h1 << twt_pkg::EV_READ);
    r(twt_pkg::OFS_EVT, p);
    wr(twt_pkg::OFS_ON, 32'h0);
    pm.burst(1'b0, 2);
    repeat (2) @(posedge clk_i);
    check(wa_q.size() + target_on_o, 32'h3);
    stop_test();
  end
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
endmodule // two_wire_target_regs_tb
`default_nettype wire
